// [shared/bus_ctl_pkg.sv]
// Shared constants and types for the asynchronous bus master control block
package bus_ctl_pkg;
	// Slow peripheral clock: period, low and high phases in processor clocks
	localparam int PCLK_PERIOD = 10;
	localparam int PCLK_LOW = 6;
	localparam int PCLK_HIGH = 4;
	// Cycle class codes
	localparam logic [2:0] CC_USER_DATA = 3'h1;
	localparam logic [2:0] CC_USER_PROG = 3'h2;
	localparam logic [2:0] CC_SUPV_DATA = 3'h5;
	localparam logic [2:0] CC_SUPV_PROG = 3'h6;
	localparam logic [2:0] CC_INT_ACK = 3'h7;
	// Access kinds requested by the core
	localparam logic [1:0] KIND_PROG = 2'h0;
	localparam logic [1:0] KIND_DATA = 2'h1;
	localparam logic [1:0] KIND_IACK = 2'h2;
	// Bus cycle states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE = 6'b00_0001,
		ST_ADDR = 6'b00_0010,
		ST_WAIT = 6'b00_0100,
		ST_PSYNC = 6'b00_1000,
		ST_PXFER = 6'b01_0000,
		ST_END = 6'b10_0000
	} bus_state_t;
	// Length of the core-requested external reset pulse, in clocks
	localparam int RST_PULSE_CYC = 124;
endpackage

// [design/periph_clk_ring.sv]
// Free-running ring counter producing the slow peripheral clock
`timescale 1ns/1ns
module periph_clk_ring
	import bus_ctl_pkg::*;
#(
	parameter int LOW_CYC = PCLK_LOW,
	parameter int HIGH_CYC = PCLK_HIGH
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	output logic pclk_o,
	output logic rise_o,
	output logic fall_o
);
	localparam int N = LOW_CYC + HIGH_CYC;
	typedef struct packed {
		logic [N-1:0] ring;
	} ring_st_t;
	ring_st_t r, nxt;
	// Rotate one bit; any lone bit pattern works, so reset value is arbitrary
	always_comb begin
		nxt = r;
		nxt.ring = {r.ring[N-2:0], r.ring[N-1]};
		// Recover from a dead ring so the clock never stalls
		if (r.ring == '0) begin
			nxt.ring = {{(N-1){1'b0}}, 1'b1};
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '0;
		end else begin
			r <= nxt;
		end
	end
	// High during the last HIGH_CYC slots
	assign pclk_o = |r.ring[N-1:LOW_CYC];
	assign rise_o = r.ring[LOW_CYC-1];
	assign fall_o = r.ring[N-1];
endmodule

// [design/async_bus_master_control.sv]
// Bus master control: reset/halt lines, peripheral clock, strobes, cycle class
`timescale 1ns/1ns
module async_bus_master_control
	import bus_ctl_pkg::*;
(
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic RSTN_I,
	// Core request side
	input wire logic REQ_VALID_I,
	output logic REQ_READY_O,
	input wire logic [22:0] REQ_ADDR_I,
	input wire logic BYTE_SELECT_BIT_I,
	input wire logic REQ_BYTE_I,
	input wire logic [1:0] REQ_KIND_I,
	input wire logic SUPERVISOR_I,
	output logic RESP_VALID_O,
	output logic [15:0] RESP_DATA_O,
	output logic RESP_AUTOVEC_O,
	// Core control and status
	input wire logic RESET_INSTR_I,
	input wire logic SELF_STOP_I,
	output logic CORE_INIT_O,
	output logic CORE_HALTED_O,
	output logic [2:0] INT_LEVEL_O,
	// Bus outputs and data input
	output logic [22:0] ADDR_O,
	output logic ADDR_OE_N_O,
	output logic [15:0] DATA_O,
	output logic DATA_OE_N_O,
	input wire logic [15:0] DATA_I,
	output logic ADDR_VALID_STROBE_N_O,
	output logic HIGH_BYTE_STROBE_N_O,
	output logic LOW_BYTE_STROBE_N_O,
	output logic READ_WRITE_O,
	output logic CTRL_OE_N_O,
	output logic [2:0] CYCLE_CLASS_CODE_O,
	// Slave answers and system inputs, active low
	input wire logic TRANSFER_ACK_IN_N_I,
	input wire logic MASTERSHIP_TAKEN_IN_N_I,
	input wire logic [2:0] INTERRUPT_LEVEL_IN_N_I,
	// Peripheral interface
	output logic PERIPH_CLK_O,
	input wire logic SYNC_PERIPH_SELECT_N_I,
	output logic PERIPH_ADDR_VALID_N_O,
	// Open-drain reset and halt lines
	input wire logic RESET_N_I,
	output logic RESET_N_O,
	output logic RESET_OE_N_O,
	input wire logic HALT_N_I,
	output logic HALT_N_O,
	output logic HALT_OE_N_O
);
	// All registered state
	typedef struct packed {
		// Bus cycle sequencer state
		bus_state_t st;
		// Address latched when the request is taken
		logic [22:0] addr;
		// Byte access flag and its lane select
		logic byte_acc;
		logic bsel;
		// Cycle class code shown while the strobe stands
		logic [2:0] cc;
		// Address strobe and the two byte strobes, active high inside
		logic avs;
		logic hbs;
		logic lbs;
		// Peripheral address valid, active high inside
		logic pav;
		// Acknowledge and peripheral select, registered once
		logic ack_s;
		logic psel_s;
		// Halt, reset and mastership lines, registered once
		logic halt_s;
		logic rst_s;
		logic taken_s;
		// Data bus, registered once so both bytes are taken together
		logic [15:0] data_s;
		// Interrupt level, registered once
		logic [2:0] ipl_s;
		// Stopped by the halt line
		logic halted;
		// System initialization in progress
		logic init;
		// Remaining clocks of the reset line pulse
		logic [7:0] rst_cnt;
		// Response pulse, data and autovector flag
		logic resp_v;
		logic [15:0] resp_d;
		logic resp_av;
		// Current cycle is an interrupt acknowledge
		logic iack;
	} st_t;
	st_t r, n;
	logic pclk, prise, pfall;
	// Peripheral clock generator, free running
	periph_clk_ring #(.LOW_CYC(PCLK_LOW), .HIGH_CYC(PCLK_HIGH)) u_ring (
		.clk_i(MCLK_I),
		.rst_n_i(RSTN_I),
		.pclk_o(pclk),
		.rise_o(prise),
		.fall_o(pfall)
	);

	// Next-state logic for the bus cycle and line handling
	// Slave returns are never used in the clock they arrive, which
	// costs one clock of latency but removes skew between lanes
	always_comb begin
		n = r;
		n.resp_v = 1'b0;
		// Register every slave return and system input once before use
		// Acknowledge is only acted on one clock after it is seen
		n.ack_s = ~TRANSFER_ACK_IN_N_I;
		// Peripheral select follows the same single stage
		n.psel_s = ~SYNC_PERIPH_SELECT_N_I;
		// Data sampled every clock; the copy taken as the cycle enters ST_END is used
		n.data_s = DATA_I;
		// Halt line, which may also be pulled by this block
		n.halt_s = ~HALT_N_I;
		// Reset line, which may also be pulled by this block
		n.rst_s = ~RESET_N_I;
		// Another master owns the bus
		n.taken_s = ~MASTERSHIP_TAKEN_IN_N_I;
		// Interrupt level, inverted to active high
		n.ipl_s = ~INTERRUPT_LEVEL_IN_N_I;

		// Reset line pulse from the reset instruction
		if (RESET_INSTR_I && r.rst_cnt == 8'h00) begin
			n.rst_cnt = 8'(RST_PULSE_CYC);
		end else if (r.rst_cnt != 8'h00) begin
			n.rst_cnt = r.rst_cnt - 8'h01;
		end
		// Initialise only when reset and halt lines are low together and no reset pulse is counting
		n.init = r.rst_s && r.halt_s && r.rst_cnt == 8'h00;
		case (r.st)
			ST_IDLE: begin
				n.halted = r.halt_s;
				if (REQ_VALID_I && !r.halt_s && !r.taken_s && !r.init) begin
					n.st = ST_ADDR;
					n.addr = REQ_ADDR_I;
					n.byte_acc = REQ_BYTE_I;
					n.bsel = BYTE_SELECT_BIT_I;
					n.iack = REQ_KIND_I == KIND_IACK;
					if (REQ_KIND_I == KIND_IACK) begin
						n.cc = CC_INT_ACK;
					end else if (REQ_KIND_I == KIND_DATA) begin
						n.cc = SUPERVISOR_I ? CC_SUPV_DATA : CC_USER_DATA;
					end else begin
						n.cc = SUPERVISOR_I ? CC_SUPV_PROG : CC_USER_PROG;
					end
				end
			end
			ST_ADDR: begin
				// Address and code settle one clock before strobes
				n.avs = 1'b1;
				n.hbs = !r.byte_acc || !r.bsel;
				n.lbs = !r.byte_acc || r.bsel;
				n.st = ST_WAIT;
			end
			ST_WAIT: begin
				if (r.ack_s) begin
					n.st = ST_END;
				end else if (r.psel_s) begin
					n.st = ST_PSYNC;
				end
			end
			ST_PSYNC: begin
				// Align to the peripheral clock's falling edge
				if (pfall) begin
					n.pav = 1'b1;
					n.st = ST_PXFER;
				end
			end
			ST_PXFER: begin
				// Data taken at end of the peripheral clock high phase
				if (pfall) begin
					n.st = ST_END;
				end
			end
			ST_END: begin
				// Strobes drop together, response issued
				n.avs = 1'b0;
				n.hbs = 1'b0;
				n.lbs = 1'b0;
				n.pav = 1'b0;
				n.resp_v = 1'b1;
				n.resp_av = r.iack && r.psel_s;
				if (!r.byte_acc) begin
					n.resp_d = r.data_s;
				end else if (r.bsel) begin
					n.resp_d = {8'h00, r.data_s[7:0]};
				end else begin
					n.resp_d = {8'h00, r.data_s[15:8]};
				end
				n.st = ST_IDLE;
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase
	end

	// State register; the reset instruction only loads the reset pulse counter here
	// Initialization clears everything except the reset and halt line samples and the init flag they drive
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			r <= '0;
			r.st <= ST_IDLE;
		end else if (r.init) begin
			// Whole core state cleared while both lines stay low
			r <= '0;
			r.st <= ST_IDLE;
			// Keep sampling the lines, else initialization could never end
			r.rst_s <= n.rst_s;
			r.halt_s <= n.halt_s;
			r.init <= r.rst_s && r.halt_s;
		end else begin
			r <= n;
		end
	end
	// Core side
	assign REQ_READY_O = r.st == ST_IDLE && !r.halt_s && !r.taken_s && !r.init;
	assign RESP_VALID_O = r.resp_v;
	assign RESP_DATA_O = r.resp_d;
	assign RESP_AUTOVEC_O = r.resp_av;
	assign CORE_INIT_O = r.init;
	assign CORE_HALTED_O = r.halted;
	// Levels sampled; only stable levels are reliable at acknowledge
	assign INT_LEVEL_O = r.ipl_s;
	// Bus drive; address floated when halted or mastership taken and strobe idle

	// Acknowledge cycles carry all ones above the serviced level
	assign ADDR_O = r.iack ? {20'hF_FFFF, r.ipl_s} : r.addr;
	// Address floats only once no strobe is standing
	assign ADDR_OE_N_O = (r.halted || r.taken_s) && !r.avs;
	// Reads only here, so the data bus is never driven
	assign DATA_O = 16'h0000;
	assign DATA_OE_N_O = 1'b1;
	// Strobes are forced idle while halted
	assign ADDR_VALID_STROBE_N_O = !r.avs || r.halted;
	assign HIGH_BYTE_STROBE_N_O = !r.hbs || r.halted;
	assign LOW_BYTE_STROBE_N_O = !r.lbs || r.halted;
	// Direction is always read in this block
	assign READ_WRITE_O = 1'b1;
	// Control lines float once another master holds the bus and no strobe is standing
	assign CTRL_OE_N_O = r.taken_s && !r.avs;
	// Code is registered, so it cannot glitch under the strobe
	assign CYCLE_CLASS_CODE_O = r.cc;
	// Peripheral clock straight from the ring
	assign PERIPH_CLK_O = pclk;
	// Peripheral address valid, active low at the pin
	assign PERIPH_ADDR_VALID_N_O = !r.pav;

	// Open drain: only ever pull low
	assign RESET_N_O = 1'b0;
	assign RESET_OE_N_O = r.rst_cnt == 8'h00;
	assign HALT_N_O = 1'b0;
	assign HALT_OE_N_O = !SELF_STOP_I;
endmodule

// [tb/bus_ctl_asserts.sv]
// Port checker for the bus master control block
`timescale 1ns/1ns
module bus_ctl_asserts (
	// Clock, reset, core side
	input wire logic MCLK_I,
	input wire logic RSTN_I,
	input wire logic REQ_VALID_I,
	input wire logic REQ_READY_O,
	input wire logic REQ_BYTE_I,
	input wire logic RESP_VALID_O,
	input wire logic SELF_STOP_I,
	input wire logic CORE_HALTED_O,
	// Bus side
	input wire logic HALT_OE_N_O,
	input wire logic ADDR_OE_N_O,
	input wire logic ADDR_VALID_STROBE_N_O,
	input wire logic HIGH_BYTE_STROBE_N_O,
	input wire logic LOW_BYTE_STROBE_N_O,
	input wire logic [2:0] CYCLE_CLASS_CODE_O,
	input wire logic TRANSFER_ACK_IN_N_I,
	input wire logic SYNC_PERIPH_SELECT_N_I,
	input wire logic PERIPH_CLK_O
);
	logic as_n; // Short alias for the address strobe
	logic take; // Request accepted at this edge
	logic pc;
	assign as_n = ADDR_VALID_STROBE_N_O;
	assign take = REQ_VALID_I && REQ_READY_O;
	assign pc = PERIPH_CLK_O;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RSTN_I);
	pclk_low_a:
	assert property ($fell(pc) |-> !pc [*6] ##1 pc) else $error("slow clock low phase");
	pclk_high_a:
	assert property ($rose(pc) |-> pc [*4] ##1 !pc) else $error("slow clock high phase");
	code_legal_a:
	assert property (!as_n |-> CYCLE_CLASS_CODE_O inside {1, 2, 5, 6, 7}) else $error("bad code");
	code_hold_a:
	assert property (!as_n && !$past(as_n) |-> $stable(CYCLE_CLASS_CODE_O)) else $error("code moved");
	word_both_a:
	assert property (take && !REQ_BYTE_I |-> ##2 !HIGH_BYTE_STROBE_N_O && !LOW_BYTE_STROBE_N_O)
	else $error("word strobes");
	byte_one_a:
	assert property (take && REQ_BYTE_I |-> ##2 HIGH_BYTE_STROBE_N_O ^ LOW_BYTE_STROBE_N_O)
	else $error("byte strobe");
	ack_ends_a:
	assert property (!TRANSFER_ACK_IN_N_I && !as_n && SYNC_PERIPH_SELECT_N_I |-> ##[1:4] RESP_VALID_O)
	else $error("ack ignored");
	halt_quiet_a:
	assert property (CORE_HALTED_O |-> as_n && ADDR_OE_N_O && HIGH_BYTE_STROBE_N_O)
	else $error("halted but active");
	self_halt_a:
	assert property (SELF_STOP_I [*2] |-> ##[0:2] !HALT_OE_N_O) else $error("halt line idle");
	cover property (take && REQ_BYTE_I);
	cover property (!SYNC_PERIPH_SELECT_N_I && !as_n);
	cover property (CORE_HALTED_O);
endmodule

// [tb/bus_slave_model.sv]
// Memory or peripheral answering read cycles
`timescale 1ns/1ns
module bus_slave_model (
	// Master strobes and address
	input wire logic clk_i,
	input wire logic as_n_i,
	input wire logic hb_n_i,
	input wire logic lb_n_i,
	input wire logic [22:0] addr_i,
	// Behaviour of this slave
	input wire logic periph_i,
	input wire logic [3:0] wait_i,
	// Answers
	output logic ack_n_o,
	output logic sel_n_o,
	output logic [15:0] data_o
);
	logic [3:0] cnt; // Cycles since strobes were seen
	logic [15:0] w; // Word stored at this address
	assign w = addr_i[15:0] ^ 16'hA5C3;
	initial begin
		cnt = 0;
		ack_n_o = 1;
		sel_n_o = 1;
		data_o = 0;
	end
	// Unstrobed or released lanes carry inverted values so stale data never matches
	always @(posedge clk_i) begin
		if (as_n_i) begin
			cnt <= 0;
			ack_n_o <= 1;
			sel_n_o <= 1;
			data_o <= ~data_o;
		end else begin
			cnt <= cnt + 1;
			sel_n_o <= !periph_i;
			data_o <= {hb_n_i ? ~w[15:8] : w[15:8], lb_n_i ? ~w[7:0] : w[7:0]};
			ack_n_o <= periph_i || cnt < wait_i;
		end
	end
endmodule

// [tb/testbench.sv]
// Self-checking bench for the bus master control block
`timescale 1ns/1ns
module testbench;
	import bus_ctl_pkg::*;
	logic MCLK_I = 0, RSTN_I = 0, REQ_VALID_I = 0, BYTE_SELECT_BIT_I = 0, REQ_BYTE_I = 0;
	logic SUPERVISOR_I = 0, RESET_INSTR_I = 0, SELF_STOP_I = 0, MASTERSHIP_TAKEN_IN_N_I = 1;
	logic [1:0] REQ_KIND_I = 0;
	logic [22:0] REQ_ADDR_I = 0;
	logic ext_rst_n = 1, ext_halt_n = 1, per = 0; // Outside drivers and slave kind
	logic [3:0] wt = 0;
	logic [2:0] ipl_n = 3'h7; // Interrupt level lines, active low
	wire REQ_READY_O, RESP_VALID_O, RESP_AUTOVEC_O, CORE_INIT_O, CORE_HALTED_O, ack_n, sel_n;
	wire AS_N, HB_N, LB_N, VMA_N, PCLK, RST_OE_N, RST_N_O, HLT_OE_N, HLT_N_O, AOE_N;
	wire [15:0] RESP_DATA_O, bus_d;
	wire [2:0] CC;
	wire [22:0] ADDR_O;
	// Open-drain lines: low when anyone pulls
	wire rst_line = ext_rst_n && (RST_OE_N || RST_N_O);
	wire halt_line = ext_halt_n && (HLT_OE_N || HLT_N_O);
	int mismatches = 0, checks_done = 0, n;
	logic [2:0] cc_seen;
	logic vma_seen;
	always #5 MCLK_I = !MCLK_I;
	// Record what the strobed cycle showed
	always @(posedge MCLK_I) begin
		if (!AS_N) cc_seen <= CC;
		if (REQ_VALID_I && REQ_READY_O) vma_seen <= 0;
		else if (!VMA_N) vma_seen <= 1;
	end
	async_bus_master_control dut_u (.MCLK_I, .RSTN_I, .REQ_VALID_I, .REQ_READY_O, .REQ_ADDR_I,
		.BYTE_SELECT_BIT_I, .REQ_BYTE_I, .REQ_KIND_I, .SUPERVISOR_I, .RESP_VALID_O, .RESP_DATA_O,
		.RESP_AUTOVEC_O, .RESET_INSTR_I, .SELF_STOP_I, .CORE_INIT_O, .CORE_HALTED_O,
		.INT_LEVEL_O(), .ADDR_O, .ADDR_OE_N_O(AOE_N), .DATA_O(), .DATA_OE_N_O(), .DATA_I(bus_d),
		.ADDR_VALID_STROBE_N_O(AS_N), .HIGH_BYTE_STROBE_N_O(HB_N), .LOW_BYTE_STROBE_N_O(LB_N),
		.READ_WRITE_O(), .CTRL_OE_N_O(), .CYCLE_CLASS_CODE_O(CC), .TRANSFER_ACK_IN_N_I(ack_n),
		.MASTERSHIP_TAKEN_IN_N_I, .INTERRUPT_LEVEL_IN_N_I(ipl_n), .PERIPH_CLK_O(PCLK),
		.SYNC_PERIPH_SELECT_N_I(sel_n), .PERIPH_ADDR_VALID_N_O(VMA_N), .RESET_N_I(rst_line),
		.RESET_N_O(RST_N_O), .RESET_OE_N_O(RST_OE_N), .HALT_N_I(halt_line), .HALT_N_O(HLT_N_O),
		.HALT_OE_N_O(HLT_OE_N));
	bus_slave_model slave_u (.clk_i(MCLK_I), .as_n_i(AS_N), .hb_n_i(HB_N), .lb_n_i(LB_N),
		.addr_i(ADDR_O), .periph_i(per), .wait_i(wt), .ack_n_o(ack_n), .sel_n_o(sel_n),
		.data_o(bus_d));
	task tick(input int c);
		repeat (c) @(posedge MCLK_I);
		#1;
	endtask
	task chk(input string nm, input logic [15:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	// One read cycle; waits bounded for acceptance and answer
	task rd(input logic [1:0] k, input logic s, b, a0, input logic [22:0] a);
		{REQ_KIND_I, SUPERVISOR_I, REQ_BYTE_I, BYTE_SELECT_BIT_I, REQ_ADDR_I} = {k, s, b, a0, a};
		REQ_VALID_I = 1;
		for (n = 0; n < 60 && REQ_READY_O !== 1; n++) tick(1);
		tick(1);
		REQ_VALID_I = 0;
		for (n = 0; n < 60 && RESP_VALID_O !== 1; n++) tick(1);
		chk("resp", RESP_VALID_O, 1);
	endtask
	task t_codes;
		for (int i = 0; i < 4; i++) begin
			rd(i[1] ? KIND_DATA : KIND_PROG, i[0], 0, 0, 23'(i * 77));
			chk("word", RESP_DATA_O, 16'(i * 77) ^ 16'hA5C3);
			chk("cc", cc_seen, {i[0], !i[1], i[1]});
		end
	endtask
	task t_bytes;
		wt = 5;
		rd(KIND_DATA, 1, 1, 0, 23'h1234);
		chk("hi", RESP_DATA_O[7:0], 8'h12 ^ 8'hA5);
		rd(KIND_DATA, 1, 1, 1, 23'h1234);
		chk("lo", RESP_DATA_O[7:0], 8'h34 ^ 8'hC3);
		wt = 0;
	endtask
	task t_periph;
		per = 1;
		rd(KIND_DATA, 0, 0, 0, 23'h0042);
		chk("pdata", RESP_DATA_O, 16'h0042 ^ 16'hA5C3);
		chk("vma", vma_seen, 1);
		ipl_n = 3'h2;
		rd(KIND_IACK, 1, 0, 0, 0);
		chk("autovec", RESP_AUTOVEC_O, 1);
		chk("iaddr", ADDR_O[15:0], 16'hFFFD);
		ipl_n = 3'h7;
		chk("iackcc", cc_seen, CC_INT_ACK);
		per = 0;
	endtask
	task t_pclk;
		@(posedge PCLK);
		for (n = 0; n < 20 && PCLK === 1; n++) tick(1);
		chk("high", 16'(n), 4);
		for (n = 0; n < 20 && PCLK === 0; n++) tick(1);
		chk("low", 16'(n), 6);
	endtask
	task t_lines;
		RESET_INSTR_I = 1;
		tick(1);
		RESET_INSTR_I = 0;
		tick(2);
		chk("rstdrv", RST_OE_N, 0);
		chk("noinit", CORE_INIT_O, 0);
		for (n = 3; n < 200 && RST_OE_N === 0; n++) tick(1);
		chk("rstlen", 16'(n > RST_PULSE_CYC - 3 && n < RST_PULSE_CYC + 3), 1);
		{ext_rst_n, ext_halt_n} = 0;
		tick(5);
		chk("init", CORE_INIT_O, 1);
		{ext_rst_n, ext_halt_n} = 2'h3;
		tick(5);
		ext_halt_n = 0;
		tick(5);
		chk("halted", CORE_HALTED_O, 1);
		chk("float", {REQ_READY_O, AOE_N}, 1);
		ext_halt_n = 1;
		SELF_STOP_I = 1;
		tick(4);
		chk("selfhalt", HLT_OE_N, 0);
		SELF_STOP_I = 0;
		MASTERSHIP_TAKEN_IN_N_I = 0;
		tick(5);
		chk("taken", {REQ_READY_O, AOE_N}, 1);
		MASTERSHIP_TAKEN_IN_N_I = 1;
		tick(8);
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		tick(5);
		RSTN_I = 1;
		t_codes;
		t_bytes;
		t_periph;
		t_pclk;
		t_lines;
		rd(KIND_PROG, 0, 0, 0, 23'h0005);
		summarize;
	end
	// Hang guard, far beyond the few hundred cycles the run needs
	initial begin
		#300000;
		mismatches++;
		summarize;
	end
endmodule
bind async_bus_master_control bus_ctl_asserts chk_u (.*);
